// file: codec_direct_register_port.sv
`timescale 1ns/1ps
// Overview of operation
// - low index bits pick the indirect register
// - fifth index bit reaches registers 16 to 31
// - gate bit blocks dma requests while irq
// - format writes need guard set; without it config writes change only the run bits
// - dac muted while mode guard is set
// - init flag reads one while codec busy
// - after init index reads 010x0000
// - index ignores writes, reads 80h when busy
// - window and pio ignore writes, read 80h when busy
// - irq flag cleared by any status write
// - irq pin follows flag only when enabled
// - play ready shows playback byte may be written
// - play side shows left or right needed
// - play half shows upper or lower needed
// - sample fault sets on overrun or underrun
// - capture ready shows fresh capture data
// - capture side shows waiting channel
// - capture half shows waiting byte
// - pio writes playback, reads capture
// - capture reads step pointer, hold last
// - playback writes step pointer, extra ignored
// - status read plus handoff restarts playback pointer
// - reserved bits zero; upper bank gated by mode
module codec_direct_register_port (
  input  wire logic       clk_sys,      // system clock
  input  wire logic       rstn,         // async reset, low
  // host bus (strobes are single-cycle, same clock)
  input  wire logic [1:0] host_addr,    // offset from base
  input  wire logic       host_rd,      // read strobe
  input  wire logic       host_wr,      // write strobe
  input  wire logic [7:0] host_wdata,   // write data
  output logic      [7:0] host_rdata,   // read data
  // indirect register file side
  output logic      [4:0] ind_addr,     // indirect index
  output logic            ind_wr,       // indirect write pulse
  output logic      [7:0] ind_wdata,    // indirect write data
  input  wire logic [7:0] ind_rdata,    // indirect read data
  // codec state inputs
  input  wire logic       init_busy,    // codec initialising
  input  wire logic [1:0] power_manage_field, // power state
  input  wire logic [1:0] compat_mode_select, // mode bits
  input  wire logic       irq_pin_gate, // pin irq enable
  input  wire logic       wide_format_play,  // 16-bit play
  input  wire logic       stereo_play,  // stereo play
  input  wire logic       adpcm_play,   // 4-byte sets
  input  wire logic       wide_format_cap,   // 16-bit capture
  input  wire logic       stereo_cap,   // stereo capture
  input  wire logic       adpcm_cap,    // 4-byte sets
  input  wire logic       codec_irq_event,   // interrupt cause
  input  wire logic       play_underrun,     // late playback
  input  wire logic       cap_overrun,       // late capture
  input  wire logic       play_dma_want,     // dma play need
  input  wire logic       cap_dma_want,      // dma capture need
  // fifo hand-off
  input  wire logic       cap_sample_valid,  // new sample pulse
  input  wire logic [31:0] cap_sample,       // sample bytes
  output logic            play_sample_valid, // sample pulse
  output logic      [31:0] play_sample,      // sample bytes
  // outputs
  output logic            play_drq,     // playback dma request
  output logic            cap_drq,      // capture dma request
  output logic            irq_out,      // irq line
  output logic            dac_mute      // dac mute
);
  // =====================================================================
  // state
  logic       mode_change_guard;  // guard flag
  logic       dma_gate_on_irq;    // request gate
  logic [4:0] index_field;        // index bits
  logic       irq_flag;           // interrupt status
  logic       sample_fault;       // sample error
  logic       busy;               // init or power down
  logic [2:0] play_ptr;           // bytes written
  logic [2:0] cap_ptr;            // bytes read
  logic       cap_fresh;          // new sample unread
  logic       status_seen;        // status read since sample
  logic       play_status_seen;   // status read after full
  logic [31:0] cap_hold;          // captured sample
  logic [31:0] play_hold;         // assembled sample
  logic [2:0] play_len;           // bytes per play sample
  logic [2:0] cap_len;            // bytes per capture sample
  logic       reg_is_guarded;     // target guarded
  // host strobe decodes
  logic       rd_index;
  logic       rd_status;
  logic       wr_window;
  logic       wr_pio;
  logic       rd_pio;
  // read path
  logic [7:0] status_byte;
  logic [7:0] next_rdata;

  // =====================================================================
  // decode
  // busy covers init and soft power-down
  assign busy      = init_busy || (power_manage_field == codec_port_pkg::PM_SOFT_DOWN);
  assign rd_index  = host_rd && (host_addr == codec_port_pkg::OFS_INDEX);
  assign rd_status = host_rd && (host_addr == codec_port_pkg::OFS_STATUS);
  assign rd_pio    = host_rd && (host_addr == codec_port_pkg::OFS_PIO) && !busy;
  assign wr_pio    = host_wr && (host_addr == codec_port_pkg::OFS_PIO) && !busy;
  assign wr_window = host_wr && (host_addr == codec_port_pkg::OFS_WINDOW) && !busy;

  // sample lengths from format: byte count is width x channels, adpcm 4
  function automatic logic [2:0] sample_len(input logic wide, input logic st,
                                            input logic ad);
    logic [2:0] n;
    n = 3'h1;
    if (ad) begin
      n = codec_port_pkg::BYTES_MAX;
    end else begin
      n = (wide ? 3'h2 : 3'h1) << st;
    end
    return n;
  endfunction
  // byte counts for each direction
  assign play_len = sample_len(wide_format_play, stereo_play, adpcm_play);
  assign cap_len  = sample_len(wide_format_cap, stereo_cap, adpcm_cap);

  // =====================================================================
  // index register: guard, gate, index
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_change_guard <= 1'b1;
      dma_gate_on_irq   <= 1'b0;
      index_field       <= 5'h00;
    end else if (host_wr && host_addr == codec_port_pkg::OFS_INDEX && !busy) begin
      // bit 7 is built on read, never stored
      mode_change_guard <= host_wdata[codec_port_pkg::IDX_GUARD_BIT];
      dma_gate_on_irq   <= host_wdata[codec_port_pkg::IDX_GATE_BIT];
      index_field[3:0]  <= host_wdata[3:0];
      // upper bank only outside basic mode
      index_field[4]    <= host_wdata[codec_port_pkg::IDX_BANK_BIT]
                           && (compat_mode_select != 2'h0);
    end
  end

  // =====================================================================
  // indirect write path with mode guard
  // upper bank hidden again whenever basic mode returns
  assign ind_addr = {index_field[4] && (compat_mode_select != 2'h0),
                     index_field[3:0]};
  assign reg_is_guarded = (ind_addr == codec_port_pkg::IND_PLAY_FMT)
                       || (ind_addr == codec_port_pkg::IND_CAP_FMT);
  always_comb begin
    ind_wr    = 1'b0;
    ind_wdata = host_wdata;
    if (wr_window) begin
      if (ind_addr == codec_port_pkg::IND_IFACE_CFG && !mode_change_guard) begin
        // run bits alone may change on the fly
        ind_wr    = 1'b1;
        ind_wdata = (ind_rdata & ~codec_port_pkg::IFACE_RUN_MASK)
                  | (host_wdata & codec_port_pkg::IFACE_RUN_MASK);
      end else begin
        ind_wr = mode_change_guard || !reg_is_guarded;
      end
    end
  end

  // output muted while guard stays set
  assign dac_mute = mode_change_guard;

  // =====================================================================
  // interrupt flag: event wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_flag <= 1'b0;
    end else if (codec_irq_event) begin
      irq_flag <= 1'b1;
    end else if (host_wr && host_addr == codec_port_pkg::OFS_STATUS) begin
      irq_flag <= 1'b0;
    end
  end
  // pin shows the flag only when enabled
  assign irq_out = irq_flag && irq_pin_gate;

  // sample fault: sticky until status write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sample_fault <= 1'b0;
    end else if (play_underrun || cap_overrun) begin
      sample_fault <= 1'b1;
    end else if (host_wr && host_addr == codec_port_pkg::OFS_STATUS) begin
      sample_fault <= 1'b0;
    end
  end

  // dma gating
  assign play_drq = play_dma_want && !(dma_gate_on_irq && irq_flag);
  assign cap_drq  = cap_dma_want  && !(dma_gate_on_irq && irq_flag);

  // =====================================================================
  // capture byte tracker
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cap_ptr     <= 3'h0;
      cap_fresh   <= 1'b0;
      status_seen <= 1'b0;
      cap_hold    <= '0;
    end else begin
      // remember a status read until a sample lands
      if (rd_status) begin
        status_seen <= 1'b1;
      end
      if (cap_sample_valid && (status_seen || rd_status)) begin
        // new sample restarts pointer after status read
        cap_hold    <= cap_sample;
        cap_ptr     <= 3'h0;
        cap_fresh   <= 1'b1;
        status_seen <= 1'b0;
      end else if (rd_pio) begin
        if (cap_ptr + 3'h1 < cap_len) begin
          cap_ptr <= cap_ptr + 3'h1;
        end else begin
          // spent sample: stay on the last byte
          cap_fresh <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // playback byte tracker
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      play_ptr          <= 3'h0;
      play_hold         <= '0;
      play_sample       <= '0;
      play_sample_valid <= 1'b0;
      play_status_seen  <= 1'b0;
    end else begin
      play_sample_valid <= 1'b0;
      // writes past the last byte fall through
      if (wr_pio && play_ptr < play_len) begin
        play_hold[8*play_ptr[1:0] +: 8] <= host_wdata;
        play_ptr <= play_ptr + 3'h1;
      end
      // note a status read once the sample is full
      if (play_ptr >= play_len && rd_status) begin
        play_status_seen <= 1'b1;
      end
      if (play_status_seen) begin
        // hand the sample on and restart
        play_sample       <= play_hold;
        play_sample_valid <= 1'b1;
        play_ptr          <= 3'h0;
        play_status_seen  <= 1'b0;
      end
    end
  end

  // =====================================================================
  // status byte
  always_comb begin
    status_byte = 8'h00;
    status_byte[codec_port_pkg::ST_IRQ_BIT]    = irq_flag;
    status_byte[codec_port_pkg::ST_PREADY_BIT] = play_ptr < play_len;
    status_byte[codec_port_pkg::ST_PSIDE_BIT]  = adpcm_play ? play_ptr < 3'h2
                          : !(stereo_play && play_ptr >= (wide_format_play ? 3'h2 : 3'h1));
    status_byte[codec_port_pkg::ST_PHALF_BIT]  = adpcm_play ? play_ptr[0]
                          : (!wide_format_play || play_ptr[0]);
    status_byte[codec_port_pkg::ST_FAULT_BIT]  = sample_fault;
    status_byte[codec_port_pkg::ST_CREADY_BIT] = cap_fresh;
    status_byte[codec_port_pkg::ST_CSIDE_BIT]  = adpcm_cap ? cap_ptr < 3'h2
                          : !(stereo_cap && cap_ptr >= (wide_format_cap ? 3'h2 : 3'h1));
    status_byte[codec_port_pkg::ST_CHALF_BIT]  = adpcm_cap ? cap_ptr[0]
                          : (!wide_format_cap || cap_ptr[0]);
  end

  // =====================================================================
  // read mux, registered data
  always_comb begin
    next_rdata = codec_port_pkg::BUSY_READ;
    // busy answers 80h except for status
    unique case (host_addr)
      codec_port_pkg::OFS_INDEX: begin
        if (!busy) begin
          next_rdata = {1'b0, mode_change_guard, dma_gate_on_irq, index_field};
        end
      end
      codec_port_pkg::OFS_WINDOW: begin
        if (!busy) begin
          next_rdata = ind_rdata;
        end
      end
      codec_port_pkg::OFS_STATUS: begin
        // status stays readable while busy
        next_rdata = status_byte;
      end
      codec_port_pkg::OFS_PIO: begin
        if (!busy) begin
          next_rdata = cap_hold[8*cap_ptr[1:0] +: 8];
        end
      end
    endcase
  end

  // data flop loads only on a read strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= next_rdata;
    end
  end

  // =====================================================================
  // checks
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq_out |-> (irq_flag && irq_pin_gate)) else $error("irq without enable");
  drq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (dma_gate_on_irq && irq_flag) |-> !play_drq && !cap_drq)
    else $error("drq while gated");
  mute_guard_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    dac_mute == mode_change_guard) else $error("mute mismatch");
  busy_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (host_rd && busy && host_addr != codec_port_pkg::OFS_STATUS)
    |=> host_rdata == codec_port_pkg::BUSY_READ) else $error("busy read not 80h");
  status_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (host_wr && host_addr == codec_port_pkg::OFS_STATUS && !codec_irq_event)
    |=> !irq_flag) else $error("irq not cleared");
  guard_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_window && reg_is_guarded && !mode_change_guard) |-> !ind_wr)
    else $error("guarded write passed");
  busy_wr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (busy && host_wr) |=> $stable(index_field) && $stable(play_ptr))
    else $error("write during busy");
  play_full_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_pio && play_ptr >= play_len && !play_status_seen) |=> $stable(play_hold))
    else $error("extra play byte taken");

  // =====================================================================
  // tracker and flag checks
  // event beats a same-cycle status write
  irq_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    codec_irq_event |=> irq_flag) else $error("irq event lost");
  // a late sample always leaves a mark
  fault_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (play_underrun || cap_overrun) |=> sample_fault) else $error("fault lost");
  // accepted sample is fresh and starts at byte 0
  cap_restart_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cap_sample_valid && (status_seen || rd_status))
    |=> cap_fresh && cap_ptr == 3'h0) else $error("capture restart");
  // a spent sample stalls on its last byte
  cap_last_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_pio && !cap_sample_valid && cap_ptr + 3'h1 >= cap_len)
    |=> $stable(cap_ptr) && !cap_fresh) else $error("capture pointer moved");
  // each capture read short of the last byte steps one byte
  cap_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_pio && !cap_sample_valid && cap_ptr + 3'h1 < cap_len)
    |=> cap_ptr == $past(cap_ptr) + 3'h1) else $error("capture step");
  // each accepted playback byte steps one lane
  play_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_pio && play_ptr < play_len)
    |=> play_ptr == $past(play_ptr) + 3'h1) else $error("play step");
  // full sample leaves one cycle after the noted status read
  play_handoff_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    play_status_seen |=> play_sample_valid && play_ptr == 3'h0)
    else $error("play handoff");
  // basic mode never reaches the upper bank
  upper_bank_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (compat_mode_select == 2'h0) |-> !ind_addr[4]) else $error("upper bank in basic mode");
  // without the guard only run bits of the config register move
  iface_run_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ind_wr && ind_addr == codec_port_pkg::IND_IFACE_CFG && !mode_change_guard)
    |-> ((ind_wdata ^ ind_rdata) & ~codec_port_pkg::IFACE_RUN_MASK) == 8'h00)
    else $error("config changed without guard");
  // a guard write shows in the flag on the next cycle
  guard_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (host_wr && host_addr == codec_port_pkg::OFS_INDEX && !busy
     && host_wdata[codec_port_pkg::IDX_GUARD_BIT]) |=> mode_change_guard)
    else $error("guard write lost");
endmodule // codec_direct_register_port

// file: codec_direct_register_port_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
// =====================================================================
// bench for the direct register port
module codec_direct_register_port_tb;
  logic        clk_sys = 1'b0;              // system clock
  logic        rstn = 1'b0;                 // reset, low
  logic [1:0]  host_addr;                   // host offset
  logic        host_rd, host_wr;            // host strobes
  logic [7:0]  host_wdata, host_rdata, rv;  // host data
  logic [4:0]  ind_addr;                    // indirect index
  logic        ind_wr;                      // indirect write pulse
  logic [7:0]  ind_wdata;                   // indirect write data
  logic [7:0]  ind_rdata = 8'h5A;           // indirect read value
  logic        init_busy = 1'b0;            // codec busy
  logic        irq_pin_gate = 1'b0;         // pin enable
  logic [1:0]  power_manage_field = 2'h0;   // power state
  logic [1:0]  compat_mode_select = 2'h0;   // mode bits
  logic [2:0]  pfmt = 3'h0;                 // play adpcm, stereo, wide
  logic [2:0]  cfmt = 3'h0;                 // capture adpcm, stereo, wide
  logic [2:0]  ev = 3'h0;                   // irq, underrun, overrun
  logic        play_dma_want = 1'b0;        // dma play need
  logic        cap_dma_want = 1'b0;         // dma capture need
  logic        cap_sample_valid = 1'b0;     // capture hand-off
  logic [31:0] cap_sample = 32'h0;          // capture lanes
  logic [31:0] play_sample, play_got;       // playback lanes
  logic        play_sample_valid;           // playback hand-off
  logic        play_seen = 1'b0;            // hand-off observed
  logic        play_drq, cap_drq, irq_out, dac_mute; // level outputs
  logic [12:0] last_wr;                     // last indirect write
  logic [2:0]  fmts [5] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b100}; // formats
  int          err_total = 0, tests_run = 0, wr_count = 0, i;
  codec_direct_register_port uut (
    .clk_sys(clk_sys), .rstn(rstn), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .ind_addr(ind_addr), .ind_wr(ind_wr), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata),
    .init_busy(init_busy), .power_manage_field(power_manage_field),
    .compat_mode_select(compat_mode_select), .irq_pin_gate(irq_pin_gate),
    .wide_format_play(pfmt[0]), .stereo_play(pfmt[1]), .adpcm_play(pfmt[2]),
    .wide_format_cap(cfmt[0]), .stereo_cap(cfmt[1]), .adpcm_cap(cfmt[2]),
    .codec_irq_event(ev[2]), .play_underrun(ev[1]), .cap_overrun(ev[0]),
    .play_dma_want(play_dma_want), .cap_dma_want(cap_dma_want),
    .cap_sample_valid(cap_sample_valid), .cap_sample(cap_sample),
    .play_sample_valid(play_sample_valid), .play_sample(play_sample),
    .play_drq(play_drq), .cap_drq(cap_drq), .irq_out(irq_out), .dac_mute(dac_mute));
  host_bus_model host (.clk_sys(clk_sys), .host_rdata(host_rdata), .host_addr(host_addr),
    .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata));
  // =====================================================================
  // clock and monitors
  always #4 clk_sys = ~clk_sys;
  // log indirect writes and playback hand-offs
  always @(posedge clk_sys) begin
    if (ind_wr === 1'b1) begin
      wr_count++;
      last_wr <= {ind_addr, ind_wdata};
    end
    if (play_sample_valid === 1'b1) begin
      play_seen <= 1'b1;
      play_got  <= play_sample;
    end
  end
  // =====================================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // masked read compare
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] m, ex, input string nm);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(nm, ex, d & m)
  endtask
  // one-cycle event pulse
  task automatic pulse(input logic [2:0] v);
    @(negedge clk_sys);
    ev = v;
    @(negedge clk_sys);
    ev = 3'h0;
  endtask
  // expected {half, side} for byte k of a sample
  function automatic logic [1:0] need(input logic [2:0] f, input int k, len);
    logic wd;
    wd = f[0] | f[2];
    need = {wd ? k[0] : 1'b1, (len == 1) ? 1'b1 : wd ? (k < 2) : (k == 0)};
  endfunction
  // fill one playback sample, overfill, hand off
  task automatic run_play(input logic [2:0] f);
    int len, k;
    logic [31:0] ex, m;
    len = f[2] ? 4 : 1 << (int'(f[0]) + int'(f[1]));
    pfmt = f;
    play_seen = 1'b0;
    for (k = 0; k < len; k++) begin
      rd_chk(codec_port_pkg::OFS_STATUS, 8'h0E, {4'h0, need(f, k, len), 2'b10}, "pstat");
      host.wr(codec_port_pkg::OFS_PIO, 8'h10 + k[7:0]);
      ex[8*k +: 8] = 8'h10 + k[7:0];
    end
    host.wr(codec_port_pkg::OFS_PIO, 8'hEE);
    rd_chk(codec_port_pkg::OFS_STATUS, 8'h02, 8'h00, "play full");
    for (k = 0; k < 8 && !play_seen; k++) @(negedge clk_sys);
    if (!play_seen) begin
      err_total++;
      print_verdict();
    end
    m = (len == 4) ? 32'hFFFFFFFF : (len == 2) ? 32'h0000FFFF : 32'h000000FF;
    `CHK("play sample", ex & m, play_got & m)
    rd_chk(codec_port_pkg::OFS_STATUS, 8'h0E, {4'h0, need(f, 0, len), 2'b10}, "prst");
  endtask
  // deliver one capture sample and read it out
  task automatic run_cap(input logic [2:0] f);
    int len, k;
    len = f[2] ? 4 : 1 << (int'(f[0]) + int'(f[1]));
    cfmt = f;
    @(negedge clk_sys);
    cap_sample = 32'hA4A3A2A1;
    cap_sample_valid = 1'b1;
    @(negedge clk_sys);
    cap_sample_valid = 1'b0;
    cap_sample = 32'h5B5C5D5E;
    for (k = 0; k < len; k++) begin
      rd_chk(codec_port_pkg::OFS_STATUS, 8'hE0, {need(f, k, len), 6'h20}, "cstat");
      rd_chk(codec_port_pkg::OFS_PIO, 8'hFF, 8'hA1 + k[7:0], "cap byte");
    end
    rd_chk(codec_port_pkg::OFS_PIO, 8'hFF, 8'hA0 + len[7:0], "cap held");
    rd_chk(codec_port_pkg::OFS_STATUS, 8'h20, 8'h00, "cap stale");
  endtask
  // =====================================================================
  // main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    `CHK("reset mute", 1'b1, dac_mute)
    rstn = 1'b1;
    rd_chk(codec_port_pkg::OFS_INDEX, 8'hFF, codec_port_pkg::INDEX_RESET, "idx rst");
    for (i = 0; i < 2; i++) begin
      init_busy = (i == 0);
      power_manage_field = (i == 0) ? 2'h0 : codec_port_pkg::PM_SOFT_DOWN;
      host.wr(codec_port_pkg::OFS_INDEX, 8'h05);
      host.wr(codec_port_pkg::OFS_PIO, 8'h77);
      rd_chk(codec_port_pkg::OFS_INDEX, 8'hFF, codec_port_pkg::BUSY_READ, "busy idx");
      rd_chk(codec_port_pkg::OFS_WINDOW, 8'hFF, codec_port_pkg::BUSY_READ, "busy win");
      rd_chk(codec_port_pkg::OFS_PIO, 8'hFF, codec_port_pkg::BUSY_READ, "busy pio");
    end
    init_busy = 1'b0;
    power_manage_field = 2'h0;
    rd_chk(codec_port_pkg::OFS_INDEX, 8'hFF, codec_port_pkg::INDEX_RESET, "idx kept");
    host.wr(codec_port_pkg::OFS_INDEX, 8'h13);
    rd_chk(codec_port_pkg::OFS_INDEX, 8'hFF, 8'h03, "bank mode0");
    compat_mode_select = 2'h2;
    host.wr(codec_port_pkg::OFS_INDEX, 8'h1C);
    `CHK("mute off", 1'b0, dac_mute)
    `CHK("ind addr", 5'h1C, ind_addr)
    host.wr(codec_port_pkg::OFS_WINDOW, 8'h0C);
    `CHK("guarded drop", 0, wr_count)
    host.wr(codec_port_pkg::OFS_INDEX, 8'h5C);
    `CHK("mute on", 1'b1, dac_mute)
    host.wr(codec_port_pkg::OFS_WINDOW, 8'h0C);
    `CHK("guarded take", 13'h1C0C, last_wr)
    host.wr(codec_port_pkg::OFS_INDEX, 8'h05);
    rd_chk(codec_port_pkg::OFS_WINDOW, 8'hFF, 8'h5A, "win read");
    host.wr(codec_port_pkg::OFS_WINDOW, 8'hA5);
    `CHK("win write", 13'h05A5, last_wr)
    host.wr(codec_port_pkg::OFS_INDEX, 8'h09);
    host.wr(codec_port_pkg::OFS_WINDOW, 8'hFF);
    `CHK("run bits only", 13'h095B, last_wr)
    host.wr(codec_port_pkg::OFS_INDEX, 8'h20);
    play_dma_want = 1'b1;
    cap_dma_want = 1'b1;
    pulse(3'b100);
    `CHK("drq gated", 2'b00, {play_drq, cap_drq})
    `CHK("irq masked", 1'b0, irq_out)
    irq_pin_gate = 1'b1;
    #1 `CHK("irq shown", 1'b1, irq_out)
    rd_chk(codec_port_pkg::OFS_STATUS, 8'h01, 8'h01, "irq flag");
    host.wr(codec_port_pkg::OFS_INDEX, 8'h00);
    `CHK("drq open", 2'b11, {play_drq, cap_drq})
    host.wr(codec_port_pkg::OFS_STATUS, 8'h5A);
    rd_chk(codec_port_pkg::OFS_STATUS, 8'h01, 8'h00, "irq clear");
    `CHK("irq low", 1'b0, irq_out)
    for (i = 0; i < 2; i++) begin
      pulse((i == 0) ? 3'b010 : 3'b001);
      rd_chk(codec_port_pkg::OFS_STATUS, 8'h10, 8'h10, "fault");
      host.wr(codec_port_pkg::OFS_STATUS, 8'h00);
      rd_chk(codec_port_pkg::OFS_STATUS, 8'h10, 8'h00, "fault clr");
    end
    for (i = 0; i < 5; i++) run_play(fmts[i]);
    for (i = 0; i < 5; i++) run_cap(fmts[i]);
    print_verdict();
  end
  // hang guard
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
endmodule // codec_direct_register_port_tb

// file: codec_port_pkg.sv
package codec_port_pkg;
  // =====================================================================
  // host address offsets
  localparam logic [1:0] OFS_INDEX  = 2'h0;
  localparam logic [1:0] OFS_WINDOW = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;
  localparam logic [1:0] OFS_PIO    = 2'h3;
  // =====================================================================
  // index_select field positions
  localparam int IDX_INIT_BIT  = 7;
  localparam int IDX_GUARD_BIT = 6;
  localparam int IDX_GATE_BIT  = 5;
  localparam int IDX_BANK_BIT  = 4;
  // =====================================================================
  // codec_status field positions
  localparam int ST_IRQ_BIT      = 0;
  localparam int ST_PREADY_BIT   = 1;
  localparam int ST_PSIDE_BIT    = 2;
  localparam int ST_PHALF_BIT    = 3;
  localparam int ST_FAULT_BIT    = 4;
  localparam int ST_CREADY_BIT   = 5;
  localparam int ST_CSIDE_BIT    = 6;
  localparam int ST_CHALF_BIT    = 7;
  // =====================================================================
  // reset values and fixed answers
  localparam logic [7:0] INDEX_RESET = 8'h40;
  localparam logic [7:0] BUSY_READ   = 8'h80;
  localparam logic [1:0] PM_SOFT_DOWN = 2'h1;
  // =====================================================================
  // indirect indices guarded by the mode-change flag
  localparam logic [4:0] IND_PLAY_FMT  = 5'h08;
  localparam logic [4:0] IND_IFACE_CFG = 5'h09;
  localparam logic [4:0] IND_CAP_FMT   = 5'h1C;
  localparam logic [7:0] IFACE_RUN_MASK = 8'h03;
  // =====================================================================
  // sample byte counts per format
  localparam logic [2:0] BYTES_MAX = 3'h4;
endpackage

// file: host_bus_model.sv
`timescale 1ns/1ps
// =====================================================================
// host processor side of the direct register port
module host_bus_model (
  input  wire logic       clk_sys,     // system clock
  input  wire logic [7:0] host_rdata,  // read data from the port
  output logic      [1:0] host_addr,   // register offset
  output logic            host_rd,     // read strobe
  output logic            host_wr,     // write strobe
  output logic      [7:0] host_wdata   // write data
);
  // bus idle at time zero
  initial begin
    host_addr  = 2'h0;
    host_rd    = 1'b0;
    host_wr    = 1'b0;
    host_wdata = 8'h00;
  end
  // one write cycle, strobe seen by exactly one rising edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(negedge clk_sys);
    host_wr    = 1'b0;
    host_wdata = ~d;
  endtask
  // one read cycle, data taken the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    host_addr = a;
    host_rd   = 1'b1;
    @(negedge clk_sys);
    host_rd = 1'b0;
    d       = host_rdata;
  endtask
endmodule // host_bus_model
